// *** sts_mode_select.sv ***
// speed/torque mode selector with start permissives and an AXI4-Lite register file
`timescale 1ns/1ns
module sts_mode_select
   import sts_pkg::*;
(
   input  wire logic        CLK_I,            // 20 MHz control clock
   input  wire logic        SYS_RST_I,        // synchronous reset, active high
   // axi4-lite slave
   input  wire logic [7:0]  S_AXI_AWADDR_I,   // write address
   input  wire logic        S_AXI_AWVALID_I,  // write address valid
   output logic             S_AXI_AWREADY_O,  // write address ready
   input  wire logic [31:0] S_AXI_WDATA_I,    // write data
   input  wire logic [3:0]  S_AXI_WSTRB_I,    // write byte strobes
   input  wire logic        S_AXI_WVALID_I,   // write data valid
   output logic             S_AXI_WREADY_O,   // write data ready
   output logic [1:0]       S_AXI_BRESP_O,    // write response
   output logic             S_AXI_BVALID_O,   // write response valid
   input  wire logic        S_AXI_BREADY_I,   // write response ready
   input  wire logic [7:0]  S_AXI_ARADDR_I,   // read address
   input  wire logic        S_AXI_ARVALID_I,  // read address valid
   output logic             S_AXI_ARREADY_O,  // read address ready
   output logic [31:0]      S_AXI_RDATA_O,    // read data
   output logic [1:0]       S_AXI_RRESP_O,    // read response
   output logic             S_AXI_RVALID_O,   // read data valid
   input  wire logic        S_AXI_RREADY_I,   // read data ready
   // same-clock datapath inputs
   input  wire logic [15:0] SPEED_REG_TORQUE_I, // speed regulator torque output, signed
   input  wire logic [11:0] FIRST_TORQUE_RAW_I, // first torque reference source
   input  wire logic [11:0] SECOND_TORQUE_RAW_I,// second torque reference source
   input  wire logic [15:0] SPEED_FEEDBACK_I, // speed feedback in rpm, signed
   // asynchronous pins
   input  wire logic        FAULT_ACTIVE_I,   // any fault active
   input  wire logic        ALARM2_ACTIVE_I,  // any type-2 alarm active
   input  wire logic        TERMINAL_ENABLE_INPUT_I, // enable terminal closed
   input  wire logic        PRECHARGE_OK_I,   // bus precharge permits start
   input  wire logic        STOP_ACTIVE_I,    // any stop input asserted
   input  wire logic        RUN_REQ_I,        // run start request
   input  wire logic        JOG_REQ_I,        // jog start request
   input  wire logic        TUNE_REQ_I,       // auto-tune start request
   // outputs
   output logic [15:0]      TORQUE_CMD_O,     // final torque command, signed
   output logic             FLUX_EN_O,        // keep motor fluxed
   output logic             SPEED_LOOP_EN_O,  // speed regulator in the loop
   output logic             READY_O,          // drive ready status
   output logic [5:0]       START_INHIBIT_O,  // inhibit vector, 1 = unmet
   output logic [2:0]       START_O,          // accepted start pulse: tune, jog, run
   output logic             IRQ_O             // level interrupt
);
   localparam int NPIN = 8;

   typedef struct packed {
      logic [NPIN-1:0]    sync1;
      logic [NPIN-1:0]    sync2;
      logic [2:0]         req_prev;
      logic               aw_have;
      logic [7:0]         aw_addr;
      logic               w_have;
      logic [31:0]        w_data;
      logic [3:0]         w_strb;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               rvalid;
      logic [31:0]        rdata;
      logic [1:0]         rresp;
      logic [31:0]        ctrl;
      logic [15:0]        first_hi;
      logic [15:0]        first_lo;
      logic [15:0]        first_div;
      logic [15:0]        second_hi;
      logic [15:0]        second_lo;
      logic [15:0]        second_mul;
      logic [15:0]        speed_par;
      logic               par_in_hz;
      logic [INH_W-1:0]   inhibit;
      logic               ready;
      logic [2:0]         mode_eff;
      logic [15:0]        torque;
      logic               speed_loop;
      logic [15:0]        speed_sts;
      logic [2:0]         start;
      logic [IRQ_W-1:0]   irq_stat;
      logic [IRQ_W-1:0]   irq_mask;
   } sts_state_t;

   sts_state_t st_r;
   sts_state_t st_nxt;

   sts_scale_if first_ch ();
   sts_scale_if second_ch ();

   sts_scaler #(.DIVIDE(1'b1)) u_first (
      .clk_i (CLK_I),
      .rst_i (SYS_RST_I),
      .ch    (first_ch)
   );

   sts_scaler #(.DIVIDE(1'b0)) u_second (
      .clk_i (CLK_I),
      .rst_i (SYS_RST_I),
      .ch    (second_ch)
   );

   assign first_ch.raw     = FIRST_TORQUE_RAW_I;
   assign first_ch.high    = st_r.first_hi;
   assign first_ch.low     = st_r.first_lo;
   assign first_ch.factor  = st_r.first_div;
   assign second_ch.raw    = SECOND_TORQUE_RAW_I;
   assign second_ch.high   = st_r.second_hi;
   assign second_ch.low    = st_r.second_lo;
   assign second_ch.factor = st_r.second_mul;

   logic [NPIN-1:0]     pins;
   logic [2:0]          mode_sel;
   logic [1:0]          units;
   logic [1:0]          new_units;
   logic signed [15:0]  spd_trq;
   logic signed [15:0]  trq_ref;
   logic signed [33:0]  trq_sum;
   logic signed [15:0]  trq_sel;
   logic [INH_W-1:0]    inh;
   logic [2:0]          req_now;
   logic [2:0]          req_rise;
   logic [IRQ_W-1:0]    irq_set;
   logic                do_write;
   logic [31:0]         wval;
   logic [31:0]         rd_val;
   logic                rd_ok;
   logic                wr_ok;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            old[8*i +: 8] = nw[8*i +: 8];
         end
      end
      merge = old;
   endfunction

   always_comb begin
      st_nxt = st_r;
      pins = {TUNE_REQ_I, JOG_REQ_I, RUN_REQ_I, STOP_ACTIVE_I, PRECHARGE_OK_I,
              TERMINAL_ENABLE_INPUT_I, ALARM2_ACTIVE_I, FAULT_ACTIVE_I};
      // two-stage synchronisers; only sync2 feeds logic
      st_nxt.sync1 = pins;
      st_nxt.sync2 = st_r.sync1;

      mode_sel = st_r.ctrl[CTRL_MODE_LSB +: 3];
      units = st_r.ctrl[CTRL_UNITS_LSB +: 2];

      // permissive conditions, re-evaluated every cycle
      inh = '0;
      inh[INH_FAULT]  = st_r.sync2[0];
      inh[INH_ALARM]  = st_r.sync2[1];
      inh[INH_ENABLE] = st_r.ctrl[CTRL_EN_CFG_BIT] & ~st_r.sync2[2];
      inh[INH_PRECHG] = ~st_r.sync2[3];
      inh[INH_STOP]   = st_r.sync2[4];
      inh[INH_EDIT]   = st_r.ctrl[CTRL_EDIT_BIT];
      st_nxt.inhibit = inh;
      st_nxt.ready = ~|inh;

      // start requests are edge-triggered and gated by ready for every kind
      req_now = st_r.sync2[7:5];
      req_rise = req_now & ~st_r.req_prev;
      st_nxt.req_prev = req_now;
      st_nxt.start = st_r.ready ? req_rise : 3'h0;

      // torque selection
      spd_trq = SPEED_REG_TORQUE_I;
      trq_sum = 34'(first_ch.scaled) + 34'(second_ch.scaled);
      trq_ref = sat16(trq_sum);
      st_nxt.mode_eff = (mode_sel > MODE_SUM) ? MODE_ZERO : mode_sel;
      st_nxt.speed_loop = 1'b0;
      unique case (st_nxt.mode_eff)
         MODE_SPEED: begin
            // takes effect next cycle: flux already up in zero torque
            trq_sel = spd_trq;
            st_nxt.speed_loop = 1'b1;
         end
         MODE_TORQ: begin
            trq_sel = trq_ref;
         end
         MODE_MIN: begin
            trq_sel = (spd_trq < trq_ref) ? spd_trq : trq_ref;
            st_nxt.speed_loop = 1'b1;
         end
         MODE_MAX: begin
            trq_sel = (spd_trq > trq_ref) ? spd_trq : trq_ref;
            st_nxt.speed_loop = 1'b1;
         end
         MODE_SUM: begin
            trq_sel = sat16(34'(spd_trq) + 34'(trq_ref));
            st_nxt.speed_loop = 1'b1;
         end
         default: begin
            trq_sel = 16'sh0000;
         end
      endcase
      st_nxt.torque = trq_sel;

      // status speed shown in hz or rpm
      if (units == UNITS_HZ || units == UNITS_CONV_HZ) begin
         st_nxt.speed_sts = 16'($signed(SPEED_FEEDBACK_I) / $signed({1'b0, RPM_PER_HZ}));
      end else begin
         st_nxt.speed_sts = SPEED_FEEDBACK_I;
      end

      // axi write: address and data taken in either order
      if (S_AXI_AWVALID_I && !st_r.aw_have) begin
         st_nxt.aw_have = 1'b1;
         st_nxt.aw_addr = S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && !st_r.w_have) begin
         st_nxt.w_have = 1'b1;
         st_nxt.w_data = S_AXI_WDATA_I;
         st_nxt.w_strb = S_AXI_WSTRB_I;
      end
      do_write = st_r.aw_have && st_r.w_have && !st_r.bvalid;
      wval = merge(st_r.ctrl, st_r.w_data, st_r.w_strb);
      new_units = wval[CTRL_UNITS_LSB +: 2];
      irq_set = '0;
      wr_ok = 1'b1;
      if (do_write) begin
         st_nxt.aw_have = 1'b0;
         st_nxt.w_have = 1'b0;
         st_nxt.bvalid = 1'b1;
         unique case ({st_r.aw_addr[7:2], 2'b00})
            OFS_CTRL: begin
               st_nxt.ctrl = wval;
               // stored speed parameter follows the converting choices only
               if (new_units == UNITS_CONV_HZ && !st_r.par_in_hz) begin
                  st_nxt.speed_par = 16'($signed(st_r.speed_par) / $signed({1'b0, RPM_PER_HZ}));
                  st_nxt.par_in_hz = 1'b1;
               end else if (new_units == UNITS_CONV_RPM && st_r.par_in_hz) begin
                  st_nxt.speed_par = sat16(34'($signed(st_r.speed_par)) * 34'($signed({1'b0, RPM_PER_HZ})));
                  st_nxt.par_in_hz = 1'b0;
               end
               if (wval[CTRL_MODE_LSB +: 3] != mode_sel) begin
                  irq_set[IRQ_MODE_CHANGE] = 1'b1;
               end
            end
            OFS_FIRST_HI:   st_nxt.first_hi   = 16'(merge({16'h0, st_r.first_hi}, st_r.w_data, st_r.w_strb));
            OFS_FIRST_LO:   st_nxt.first_lo   = 16'(merge({16'h0, st_r.first_lo}, st_r.w_data, st_r.w_strb));
            OFS_FIRST_DIV:  st_nxt.first_div  = 16'(merge({16'h0, st_r.first_div}, st_r.w_data, st_r.w_strb));
            OFS_SECOND_HI:  st_nxt.second_hi  = 16'(merge({16'h0, st_r.second_hi}, st_r.w_data, st_r.w_strb));
            OFS_SECOND_LO:  st_nxt.second_lo  = 16'(merge({16'h0, st_r.second_lo}, st_r.w_data, st_r.w_strb));
            OFS_SECOND_MUL: st_nxt.second_mul = 16'(merge({16'h0, st_r.second_mul}, st_r.w_data, st_r.w_strb));
            OFS_SPEED_PAR:  st_nxt.speed_par  = 16'(merge({16'h0, st_r.speed_par}, st_r.w_data, st_r.w_strb));
            OFS_IRQ_STAT: begin
               if (st_r.w_strb[0]) begin
                  st_nxt.irq_stat = st_r.irq_stat & ~st_r.w_data[IRQ_W-1:0];
               end
            end
            OFS_IRQ_MASK: begin
               if (st_r.w_strb[0]) begin
                  st_nxt.irq_mask = st_r.w_data[IRQ_W-1:0];
               end
            end
            OFS_STATUS, OFS_TORQUE, OFS_SPEED_STS: begin
               // read-only words: write ignored, still okay
            end
            default: wr_ok = 1'b0;
         endcase
         st_nxt.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (st_r.bvalid && S_AXI_BREADY_I) begin
         st_nxt.bvalid = 1'b0;
      end

      // axi read, answered one cycle after the address is taken
      rd_ok = 1'b1;
      unique case ({S_AXI_ARADDR_I[7:2], 2'b00})
         OFS_CTRL:       rd_val = st_r.ctrl;
         OFS_FIRST_HI:   rd_val = {16'h0, st_r.first_hi};
         OFS_FIRST_LO:   rd_val = {16'h0, st_r.first_lo};
         OFS_FIRST_DIV:  rd_val = {16'h0, st_r.first_div};
         OFS_SECOND_HI:  rd_val = {16'h0, st_r.second_hi};
         OFS_SECOND_LO:  rd_val = {16'h0, st_r.second_lo};
         OFS_SECOND_MUL: rd_val = {16'h0, st_r.second_mul};
         OFS_SPEED_PAR:  rd_val = {16'h0, st_r.speed_par};
         OFS_STATUS:     rd_val = {20'h0, st_r.mode_eff, st_r.ready, 2'h0, st_r.inhibit};
         OFS_TORQUE:     rd_val = {16'h0, st_r.torque};
         OFS_SPEED_STS:  rd_val = {16'h0, st_r.speed_sts};
         OFS_IRQ_STAT:   rd_val = {28'h0, st_r.irq_stat};
         OFS_IRQ_MASK:   rd_val = {28'h0, st_r.irq_mask};
         default: begin
            rd_val = 32'h0000_0000;
            rd_ok = 1'b0;
         end
      endcase
      if (S_AXI_ARVALID_I && !st_r.rvalid) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata = rd_val;
         st_nxt.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (st_r.rvalid && S_AXI_RREADY_I) begin
         st_nxt.rvalid = 1'b0;
      end

      // events; a set in the clearing cycle survives the clear
      irq_set[IRQ_READY_UP] = st_nxt.ready & ~st_r.ready;
      irq_set[IRQ_INHIBIT_UP] = |(inh & ~st_r.inhibit);
      irq_set[IRQ_START_REFUSED] = ~st_r.ready & |req_rise;
      st_nxt.irq_stat = st_nxt.irq_stat | irq_set;
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         st_r <= '0;
         st_r.ctrl <= RST_CTRL;
         st_r.first_hi <= RST_SCALE_HI;
         st_r.first_lo <= RST_SCALE_LO;
         st_r.first_div <= RST_FACTOR;
         st_r.second_hi <= RST_SCALE_HI;
         st_r.second_lo <= RST_SCALE_LO;
         st_r.second_mul <= RST_FACTOR;
         st_r.speed_par <= RST_SPEED_PAR;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign S_AXI_AWREADY_O = ~st_r.aw_have;
   assign S_AXI_WREADY_O  = ~st_r.w_have;
   assign S_AXI_BVALID_O  = st_r.bvalid;
   assign S_AXI_BRESP_O   = st_r.bresp;
   assign S_AXI_ARREADY_O = ~st_r.rvalid;
   assign S_AXI_RVALID_O  = st_r.rvalid;
   assign S_AXI_RDATA_O   = st_r.rdata;
   assign S_AXI_RRESP_O   = st_r.rresp;
   assign TORQUE_CMD_O    = st_r.torque;
   // flux held in every mode, zero torque included
   assign FLUX_EN_O       = st_r.ready;
   assign SPEED_LOOP_EN_O = st_r.speed_loop;
   assign READY_O         = st_r.ready;
   assign START_INHIBIT_O = st_r.inhibit;
   assign START_O         = st_r.start;
   assign IRQ_O           = |(st_r.irq_stat & st_r.irq_mask);
endmodule

// *** sts_pkg.sv ***
// shared constants and the sat16 saturation function for the speed/torque mode selector
package sts_pkg;
   localparam int DW = 16;
   localparam int RAW_W = 12;
   localparam int RAW_SHIFT = 12;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_FIRST_HI  = 8'h04;
   localparam logic [7:0] OFS_FIRST_LO  = 8'h08;
   localparam logic [7:0] OFS_FIRST_DIV = 8'h0c;
   localparam logic [7:0] OFS_SECOND_HI = 8'h10;
   localparam logic [7:0] OFS_SECOND_LO = 8'h14;
   localparam logic [7:0] OFS_SECOND_MUL = 8'h18;
   localparam logic [7:0] OFS_SPEED_PAR = 8'h1c;
   localparam logic [7:0] OFS_STATUS    = 8'h20;
   localparam logic [7:0] OFS_TORQUE    = 8'h24;
   localparam logic [7:0] OFS_SPEED_STS = 8'h28;
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h2c;
   localparam logic [7:0] OFS_IRQ_MASK  = 8'h30;

   // control field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_UNITS_LSB = 4;
   localparam int CTRL_EN_CFG_BIT = 8;
   localparam int CTRL_EDIT_BIT = 9;

   // operating modes
   localparam logic [2:0] MODE_ZERO  = 3'h0;
   localparam logic [2:0] MODE_SPEED = 3'h1;
   localparam logic [2:0] MODE_TORQ  = 3'h2;
   localparam logic [2:0] MODE_MIN   = 3'h3;
   localparam logic [2:0] MODE_MAX   = 3'h4;
   localparam logic [2:0] MODE_SUM   = 3'h5;

   // speed unit choices
   localparam logic [1:0] UNITS_HZ      = 2'h0;
   localparam logic [1:0] UNITS_RPM     = 2'h1;
   localparam logic [1:0] UNITS_CONV_HZ = 2'h2;
   localparam logic [1:0] UNITS_CONV_RPM = 2'h3;
   localparam logic [15:0] RPM_PER_HZ   = 16'h001e;

   // inhibit vector bit positions
   localparam int INH_FAULT = 0;
   localparam int INH_ALARM = 1;
   localparam int INH_ENABLE = 2;
   localparam int INH_PRECHG = 3;
   localparam int INH_STOP = 4;
   localparam int INH_EDIT = 5;
   localparam int INH_W = 6;

   // interrupt status bit positions
   localparam int IRQ_READY_UP = 0;
   localparam int IRQ_INHIBIT_UP = 1;
   localparam int IRQ_START_REFUSED = 2;
   localparam int IRQ_MODE_CHANGE = 3;
   localparam int IRQ_W = 4;

   // reset values
   localparam logic [31:0] RST_CTRL    = 32'h0000_0000;
   localparam logic [15:0] RST_SCALE_HI = 16'h1000;
   localparam logic [15:0] RST_SCALE_LO = 16'h0000;
   localparam logic [15:0] RST_FACTOR  = 16'h0001;
   localparam logic [15:0] RST_SPEED_PAR = 16'h0000;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   function automatic logic signed [15:0] sat16(input logic signed [33:0] v);
      if (v > 34'sd32767) begin
         sat16 = 16'sh7fff;
      end else if (v < -34'sd32768) begin
         sat16 = 16'sh8000;
      end else begin
         sat16 = v[15:0];
      end
   endfunction
endpackage

// *** sts_scale_if.sv ***
// one torque reference channel between the selector and its scaler
`timescale 1ns/1ns
interface sts_scale_if;
   logic        [11:0] raw;
   logic signed [15:0] high;
   logic signed [15:0] low;
   logic signed [15:0] factor;
   logic signed [15:0] scaled;
   modport host (output raw, output high, output low, output factor, input scaled);
   modport unit (input raw, input high, input low, input factor, output scaled);
endinterface

// *** sts_scaler.sv ***
// linear scaling of one torque reference, then divide or multiply
`timescale 1ns/1ns
module sts_scaler
   import sts_pkg::*;
#(
   parameter bit DIVIDE = 1'b1
) (
   input  wire logic    clk_i,   // control clock
   input  wire logic    rst_i,   // synchronous reset
   sts_scale_if.unit    ch       // channel settings and result
);
   typedef struct packed {
      logic signed [15:0] scaled;
   } sts_scaler_state_t;

   sts_scaler_state_t st_r;
   sts_scaler_state_t st_nxt;

   logic signed [16:0] span;
   logic signed [33:0] prod;
   logic signed [33:0] lin;
   logic signed [33:0] fac;
   logic signed [33:0] res;

   always_comb begin
      span = 17'(ch.high) - 17'(ch.low);
      prod = 34'(span) * $signed({22'h0, ch.raw});
      lin = 34'(ch.low) + (prod >>> RAW_SHIFT);
      fac = 34'(ch.factor);
      if (DIVIDE) begin
         // a zero divisor would be undefined; pass the value through
         res = (fac == 34'sd0) ? lin : lin / fac;
      end else begin
         res = lin * fac;
      end
      st_nxt = st_r;
      st_nxt.scaled = sat16(res);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign ch.scaled = st_r.scaled;
endmodule

// *** sts_src_model.sv ***
// speed regulator and torque reference sources feeding the selector
`timescale 1ns/1ns
module sts_src_model (
   input  wire logic        clk_i,    // control clock
   input  wire logic [15:0] trq_set_i, // regulator torque to present
   input  wire logic [11:0] a_set_i,  // first reference level
   input  wire logic [11:0] b_set_i,  // second reference level
   output logic      [15:0] trq_o,    // regulator torque output
   output logic      [11:0] a_o,      // first reference source
   output logic      [11:0] b_o       // second reference source
);
   // sources update on the control clock, like the real upstream blocks
   always_ff @(posedge clk_i) begin
      trq_o <= trq_set_i;
      a_o   <= a_set_i;
      b_o   <= b_set_i;
   end
endmodule

// *** sts_mode_select_asserts.sv ***
// checker for the mode selector ports
`timescale 1ns/1ns
module sts_mode_select_asserts
   import sts_pkg::*;
(
   input wire logic CLK_I, SYS_RST_I, S_AXI_AWVALID_I, S_AXI_AWREADY_O, S_AXI_WVALID_I, S_AXI_WREADY_O,
   input wire logic S_AXI_BVALID_O, S_AXI_BREADY_I, S_AXI_RVALID_O, S_AXI_RREADY_I, S_AXI_ARREADY_O,
   input wire logic [7:0] S_AXI_AWADDR_I,
   input wire logic [31:0] S_AXI_WDATA_I, S_AXI_RDATA_O,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic [1:0] S_AXI_BRESP_O,
   input wire logic [15:0] SPEED_REG_TORQUE_I, TORQUE_CMD_O,
   input wire logic FAULT_ACTIVE_I, FLUX_EN_O, SPEED_LOOP_EN_O, READY_O,
   input wire logic [5:0] START_INHIBIT_O,
   input wire logic [2:0] START_O
);
   logic [3:0] up_cnt;
   logic [2:0] mode_r;
   logic       settled;
   assign settled = up_cnt > 4'h7;
   // shadow of the mode field; only writes with strobe bit 0 set and both channels together are tracked
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         up_cnt <= 4'h0;
         mode_r <= 3'h0;
      end else begin
         if (up_cnt != 4'hf) up_cnt <= up_cnt + 4'h1;
         if (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O
             && S_AXI_AWADDR_I == OFS_CTRL && S_AXI_WSTRB_I[0]) mode_r <= S_AXI_WDATA_I[2:0];
      end
   end
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);
   chk_zero_torque: assert property ((mode_r == 3'h0 || mode_r > 3'h5)[*4] |-> TORQUE_CMD_O == 16'h0)
      else $error("torque not zero in zero mode");
   chk_speed_torque: assert property ((mode_r == 3'h1 && $stable(SPEED_REG_TORQUE_I))[*4]
      |-> TORQUE_CMD_O == SPEED_REG_TORQUE_I) else $error("speed mode torque wrong");
   chk_loop_enable: assert property ((mode_r inside {3'h1, 3'h3, 3'h4, 3'h5})[*4] |-> SPEED_LOOP_EN_O)
      else $error("speed loop not enabled");
   chk_fault_inhibit: assert property ((settled && $stable(FAULT_ACTIVE_I))[*5]
      |-> START_INHIBIT_O[INH_FAULT] == FAULT_ACTIVE_I) else $error("fault inhibit bit wrong");
   chk_ready_gate: assert property (settled |-> READY_O == (START_INHIBIT_O == 6'h0))
      else $error("ready not tied to inhibit vector");
   chk_flux_ready: assert property (FLUX_EN_O == READY_O) else $error("flux enable differs from ready");
   chk_start_gate: assert property (START_O != 3'h0 |-> $past(READY_O))
      else $error("start accepted while not ready");
   chk_start_pulse: assert property (START_O[0] |=> !START_O[0]) else $error("start pulse too long");
   chk_bresp_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
      else $error("write response dropped");
   chk_rdata_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
      else $error("read data dropped");
   cov_start: cover property (START_O[0]);
   cov_ready: cover property ($rose(READY_O));
   cov_sum: cover property (mode_r == 3'h5 && SPEED_LOOP_EN_O);
endmodule
bind sts_mode_select sts_mode_select_asserts chk (.*);

// *** sts_mode_select_test.sv ***
// self-checking bench for the mode selector
`timescale 1ns/1ns
module sts_mode_select_test;
   import sts_pkg::*;
   logic CLK_I, SYS_RST_I, S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I, S_AXI_ARVALID_I, S_AXI_RREADY_I;
   logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
   logic [7:0] S_AXI_AWADDR_I, S_AXI_ARADDR_I;
   logic [31:0] S_AXI_WDATA_I, S_AXI_RDATA_O;
   logic [3:0] S_AXI_WSTRB_I;
   logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, r;
   logic [15:0] SPEED_REG_TORQUE_I, SPEED_FEEDBACK_I, TORQUE_CMD_O, trq_set;
   logic [11:0] FIRST_TORQUE_RAW_I, SECOND_TORQUE_RAW_I, a_set, b_set;
   logic FAULT_ACTIVE_I, ALARM2_ACTIVE_I, TERMINAL_ENABLE_INPUT_I, PRECHARGE_OK_I, STOP_ACTIVE_I;
   logic RUN_REQ_I, JOG_REQ_I, TUNE_REQ_I, FLUX_EN_O, SPEED_LOOP_EN_O, READY_O, IRQ_O;
   logic [5:0] START_INHIBIT_O;
   logic [2:0] START_O;
   logic [31:0] d;
   int failures, n_tests;
   sts_mode_select dut (.*);
   sts_src_model src (.clk_i(CLK_I), .trq_set_i(trq_set), .a_set_i(a_set), .b_set_i(b_set),
      .trq_o(SPEED_REG_TORQUE_I), .a_o(FIRST_TORQUE_RAW_I), .b_o(SECOND_TORQUE_RAW_I));
   initial begin
      CLK_I = 1'b0;
      forever #25 CLK_I = ~CLK_I;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge CLK_I);
      @(negedge CLK_I);
   endtask
   // readies are looked at on the falling edge, where they equal their value at the next rising edge
   task automatic wr(input logic [7:0] a, input logic [31:0] dt, output logic [1:0] rs);
      logic ha, hw, hb;
      @(posedge CLK_I);
      {S_AXI_AWADDR_I, S_AXI_WDATA_I, S_AXI_WSTRB_I} <= {a, dt, 4'hf};
      {S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I} <= 3'b111;
      forever begin
         @(negedge CLK_I);
         ha = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
         hw = S_AXI_WVALID_I && S_AXI_WREADY_O;
         hb = S_AXI_BVALID_O;
         rs = S_AXI_BRESP_O;
         @(posedge CLK_I);
         if (ha) S_AXI_AWVALID_I <= 1'b0;
         if (hw) S_AXI_WVALID_I <= 1'b0;
         if (hb) break;
      end
      S_AXI_BREADY_I <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rs);
      logic ha, hv;
      @(posedge CLK_I);
      S_AXI_ARADDR_I <= a;
      {S_AXI_ARVALID_I, S_AXI_RREADY_I} <= 2'b11;
      forever begin
         @(negedge CLK_I);
         {ha, hv, dt, rs} = {S_AXI_ARREADY_O, S_AXI_RVALID_O, S_AXI_RDATA_O, S_AXI_RRESP_O};
         @(posedge CLK_I);
         if (ha) S_AXI_ARVALID_I <= 1'b0;
         if (hv) break;
      end
      {S_AXI_ARVALID_I, S_AXI_RREADY_I} <= 2'b00;
   endtask
   task automatic t_modes();
      logic [15:0] exp [8] = '{16'd0, 16'd300, 16'd150, 16'd150, 16'd300, 16'd450, 16'd0, 16'd0};
      for (int m = 0; m < 8; m++) begin
         wr(OFS_CTRL, 32'(m), r);
         tick(4);
         chk("torque", {16'h0, TORQUE_CMD_O}, {16'h0, exp[m]});
         chk("loop", SPEED_LOOP_EN_O, m == 1 || (m > 2 && m < 6));
         chk("flux", FLUX_EN_O, 1'b1);
      end
   endtask
   task automatic t_scale();
      wr(OFS_FIRST_HI, 32'h0800, r);
      wr(OFS_FIRST_LO, 32'h0010, r);
      wr(OFS_FIRST_DIV, 32'h0002, r);
      wr(OFS_SECOND_MUL, 32'h0003, r);
      wr(OFS_CTRL, 32'h2, r);
      tick(5);
      chk("scaled", {16'h0, TORQUE_CMD_O}, 32'd182);
   endtask
   task automatic cause(input int i, input logic v);
      @(posedge CLK_I);
      case (i)
         0: FAULT_ACTIVE_I <= v;
         1: ALARM2_ACTIVE_I <= v;
         2: wr(OFS_CTRL, v ? 32'h100 : 32'h0, r);
         3: PRECHARGE_OK_I <= !v;
         4: STOP_ACTIVE_I <= v;
         default: wr(OFS_CTRL, v ? 32'h200 : 32'h0, r);
      endcase
      tick(6);
   endtask
   task automatic t_permit();
      for (int i = 0; i < 6; i++) begin
         cause(i, 1'b1);
         chk("inhibit", START_INHIBIT_O, 6'h1 << i);
         chk("ready", READY_O, 1'b0);
         cause(i, 1'b0);
      end
      TERMINAL_ENABLE_INPUT_I <= 1'b1;
      cause(2, 1'b1);
      chk("enable", START_INHIBIT_O, 6'h0);
      for (int j = 0; j < 3; j++) begin
         {TUNE_REQ_I, JOG_REQ_I, RUN_REQ_I} <= 3'(1 << j);
         d = 0;
         for (int n = 0; n < 10 && d == 0; n++) begin
            tick(0);
            d = START_O;
            @(posedge CLK_I);
         end
         chk("start", d, 1 << j);
         {TUNE_REQ_I, JOG_REQ_I, RUN_REQ_I} <= 3'h0;
         @(posedge CLK_I);
      end
      cause(0, 1'b1);
      RUN_REQ_I <= 1'b1;
      d = 0;
      repeat (8) begin
         tick(0);
         d = d | START_O;
      end
      chk("refused", d, 3'h0);
   endtask
   task automatic t_regs();
      rd(OFS_IRQ_STAT, d, r);
      chk("irqstat", d & 32'hc, 32'hc);
      chk("irqoff", IRQ_O, 1'b0);
      wr(OFS_IRQ_MASK, 32'h4, r);
      tick(1);
      chk("irqon", IRQ_O, 1'b1);
      wr(OFS_IRQ_STAT, 32'h4, r);
      tick(1);
      chk("irqclr", IRQ_O, 1'b0);
      wr(OFS_CTRL, 32'h30, r);
      wr(OFS_SPEED_PAR, 32'd1800, r);
      wr(OFS_CTRL, 32'h20, r);
      rd(OFS_SPEED_PAR, d, r);
      chk("tohz", d, 32'd60);
      rd(OFS_SPEED_STS, d, r);
      chk("spdhz", d, 32'd60);
      wr(OFS_CTRL, 32'h30, r);
      rd(OFS_SPEED_PAR, d, r);
      chk("torpm", d, 32'd1800);
      wr(8'h3c, 32'h1, r);
      chk("wrerr", r, RESP_SLVERR);
      rd(8'h3c, d, r);
      chk("rderr", d, 32'h0);
      chk("rderr", r, RESP_SLVERR);
   endtask
   task automatic give_verdict();
      if (failures == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge CLK_I);
      failures++;
      give_verdict();
   end
   initial begin
      {S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I, S_AXI_ARVALID_I, S_AXI_RREADY_I} = 5'h0;
      {S_AXI_AWADDR_I, S_AXI_ARADDR_I, S_AXI_WDATA_I, S_AXI_WSTRB_I} = '0;
      {trq_set, a_set, b_set, SPEED_FEEDBACK_I} = {16'd300, 12'd100, 12'd50, 16'd1800};
      {FAULT_ACTIVE_I, ALARM2_ACTIVE_I, TERMINAL_ENABLE_INPUT_I, STOP_ACTIVE_I} = 4'h0;
      {RUN_REQ_I, JOG_REQ_I, TUNE_REQ_I, PRECHARGE_OK_I} = 4'h1;
      SYS_RST_I = 1'b1;
      repeat (10) @(posedge CLK_I);
      SYS_RST_I <= 1'b0;
      tick(6);
      t_modes();
      t_scale();
      t_permit();
      t_regs();
      give_verdict();
   end
endmodule
